// >>> logic/tmw_pkg.sv
// package of the timer and watchdog block: register map, field layout, reset values,
// timing counts and the packed state carrier.
// assumes a single core clock and an APB master with 32-bit data.
package tmw_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_FREQ_MHZ      = 100;
  localparam int unsigned WDG_RST_TIME_NS   = 1000;
  localparam int unsigned WDG_RST_CYCLES    =
    (WDG_RST_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;

  // ---------------------------------------------------------------
  // sizes and the watchdog status bit position
  // ---------------------------------------------------------------
  localparam int unsigned NUM_CH     = 4;
  localparam int unsigned CNT_W      = 32;
  localparam int unsigned STAT_W     = NUM_CH + 1;
  localparam int unsigned WDG_STAT_BIT = NUM_CH;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_LOAD_BASE  = 8'h10;
  localparam logic [7:0] OFS_COUNT_BASE = 8'h20;
  localparam logic [7:0] OFS_WDG_CTRL   = 8'h30;
  localparam logic [7:0] OFS_WDG_LOAD   = 8'h34;
  localparam logic [7:0] OFS_WDG_SVC    = 8'h38;
  localparam logic [7:0] OFS_WDG_COUNT  = 8'h3c;
  localparam logic [7:0] OFS_STATUS     = 8'h40;
  localparam logic [7:0] OFS_MASK       = 8'h44;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_EN_POS   = 0;
  localparam int unsigned CTRL_MODE_POS = 4;
  localparam int unsigned WDG_EN_POS    = 0;
  localparam int unsigned WDG_ACT_POS   = 1;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [CNT_W-1:0]  RST_LOAD     = 32'hffffffff;
  localparam logic [CNT_W-1:0]  RST_WDG_LOAD = 32'hffffffff;
  localparam logic [STAT_W-1:0] RST_MASK     = 5'h00;

  typedef enum logic {
    TMW_MODE_TIMER,
    TMW_MODE_COUNTER
  } tmw_mode_e;

  typedef enum logic {
    TMW_WDG_NMI,
    TMW_WDG_RESET
  } tmw_wdg_act_e;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [7:0]        paddr;
    logic [31:0]       pwdata;
  } tmw_apb_req_s;

  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } tmw_apb_rsp_s;

  typedef struct packed {
    logic [NUM_CH-1:0][CNT_W-1:0] cnt;
    logic [NUM_CH-1:0][CNT_W-1:0] load;
    logic [NUM_CH-1:0]            en;
    tmw_mode_e [NUM_CH-1:0]       mode;
    logic                         wdg_en;
    tmw_wdg_act_e                 wdg_act;
    logic [CNT_W-1:0]             wdg_load;
    logic [CNT_W-1:0]             wdg_cnt;
    logic [STAT_W-1:0]            status;
    logic [STAT_W-1:0]            mask;
    tmw_apb_rsp_s                 rsp;
    logic [NUM_CH-1:0]            ch_irq;
    logic                         irq;
    logic                         nmi;
    logic [15:0]                  rst_cnt;
    logic                         sys_rst;
  } tmw_state_s;

endpackage

// >>> logic/tmw_timers.sv
// timer/counter channels and count-down watchdog with an APB register slave.
// assumes one core clock, a synchronous active-low reset and a standard APB master.
`timescale 1ns/10ps

module tmw_timers (
  input  wire logic                  clock_in,
  input  wire logic                  reset_n_in,
  input  wire tmw_pkg::tmw_apb_req_s apb_req_in,
  output tmw_pkg::tmw_apb_rsp_s      apb_rsp_out,
  output logic [3:0]                 ch_irq_out,
  output logic                       irq_out,
  output logic                       nmi_out,
  output logic                       sys_reset_out
);
  import tmw_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [CNT_W-1:0] dec_cnt(input logic [CNT_W-1:0] v);
    dec_cnt = v - 32'h00000001;
  endfunction

  function automatic logic [31:0] zext_stat(input logic [STAT_W-1:0] v);
    zext_stat = {27'h0000000, v};
  endfunction

  tmw_state_s state;
  tmw_state_s next_state;

  logic              acc;
  logic              wr_now;
  logic [STAT_W-1:0] set_bits;
  logic [STAT_W-1:0] clr_bits;
  logic              svc;
  logic [31:0]       rd;
  logic              bad;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    set_bits   = '0;
    clr_bits   = '0;
    svc        = 1'b0;
    rd         = 32'h00000000;
    bad        = 1'b0;

    // one wait state: pready rises in the second access cycle, so prdata is a flop
    acc    = apb_req_in.psel && apb_req_in.penable;
    wr_now = acc && apb_req_in.pwrite && state.rsp.pready;

    // read and unmapped decode
    if (apb_req_in.paddr == OFS_CTRL) begin
      for (int i = 0; i < NUM_CH; i++) begin
        rd[CTRL_EN_POS + i]   = state.en[i];
        rd[CTRL_MODE_POS + i] = state.mode[i];
      end
    end else if (apb_req_in.paddr >= OFS_LOAD_BASE && apb_req_in.paddr < OFS_COUNT_BASE
                 && apb_req_in.paddr[1:0] == 2'h0) begin
      rd = state.load[apb_req_in.paddr[3:2]];
    end else if (apb_req_in.paddr >= OFS_COUNT_BASE && apb_req_in.paddr < OFS_WDG_CTRL
                 && apb_req_in.paddr[1:0] == 2'h0) begin
      rd = state.cnt[apb_req_in.paddr[3:2]];
    end else if (apb_req_in.paddr == OFS_WDG_CTRL) begin
      rd[WDG_EN_POS]  = state.wdg_en;
      rd[WDG_ACT_POS] = state.wdg_act;
    end else if (apb_req_in.paddr == OFS_WDG_LOAD) begin
      rd = state.wdg_load;
    end else if (apb_req_in.paddr == OFS_WDG_SVC) begin
      rd = 32'h00000000;
    end else if (apb_req_in.paddr == OFS_WDG_COUNT) begin
      rd = state.wdg_cnt;
    end else if (apb_req_in.paddr == OFS_STATUS) begin
      rd = zext_stat(state.status);
    end else if (apb_req_in.paddr == OFS_MASK) begin
      rd = zext_stat(state.mask);
    end else begin
      bad = 1'b1;
    end

    // apb handshake
    if (acc && !state.rsp.pready) begin
      next_state.rsp.pready  = 1'b1;
      next_state.rsp.pslverr = bad;
      next_state.rsp.prdata  = apb_req_in.pwrite ? 32'h00000000 : rd;
    end else begin
      next_state.rsp.pready  = 1'b0;
      next_state.rsp.pslverr = 1'b0;
      next_state.rsp.prdata  = 32'h00000000;
    end

    // ---------------------------------------------------------------
    // channels
    // ---------------------------------------------------------------
    for (int i = 0; i < NUM_CH; i++) begin
      if (state.en[i]) begin
        if (state.cnt[i] == '0) begin
          set_bits[i] = 1'b1;
          if (state.mode[i] == TMW_MODE_TIMER) begin
            next_state.cnt[i] = state.load[i];
          end else begin
            next_state.en[i] = 1'b0;
          end
        end else begin
          next_state.cnt[i] = dec_cnt(state.cnt[i]);
        end
      end
    end

    // ---------------------------------------------------------------
    // watchdog
    // ---------------------------------------------------------------
    svc = wr_now && apb_req_in.paddr == OFS_WDG_SVC;
    if (state.wdg_en) begin
      if (svc) begin
        next_state.wdg_cnt = state.wdg_load;
      end else if (state.wdg_cnt == '0) begin
        set_bits[WDG_STAT_BIT] = 1'b1;
        next_state.wdg_cnt     = state.wdg_load;
      end else begin
        next_state.wdg_cnt = dec_cnt(state.wdg_cnt);
      end
    end

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    if (wr_now) begin
      if (apb_req_in.paddr == OFS_CTRL) begin
        for (int i = 0; i < NUM_CH; i++) begin
          next_state.en[i]   = apb_req_in.pwdata[CTRL_EN_POS + i];
          next_state.mode[i] = tmw_mode_e'(apb_req_in.pwdata[CTRL_MODE_POS + i]);
          if (apb_req_in.pwdata[CTRL_EN_POS + i] && !state.en[i]) begin
            next_state.cnt[i] = state.load[i];
          end
        end
      end else if (apb_req_in.paddr >= OFS_LOAD_BASE && apb_req_in.paddr < OFS_COUNT_BASE
                   && apb_req_in.paddr[1:0] == 2'h0) begin
        next_state.load[apb_req_in.paddr[3:2]] = apb_req_in.pwdata;
        next_state.cnt[apb_req_in.paddr[3:2]]  = apb_req_in.pwdata;
      end else if (apb_req_in.paddr == OFS_WDG_CTRL) begin
        // once running the watchdog ignores disable and action changes
        if (!state.wdg_en) begin
          next_state.wdg_en  = apb_req_in.pwdata[WDG_EN_POS];
          next_state.wdg_act = tmw_wdg_act_e'(apb_req_in.pwdata[WDG_ACT_POS]);
          next_state.wdg_cnt = state.wdg_load;
        end
      end else if (apb_req_in.paddr == OFS_WDG_LOAD) begin
        next_state.wdg_load = apb_req_in.pwdata;
      end else if (apb_req_in.paddr == OFS_STATUS) begin
        clr_bits = apb_req_in.pwdata[STAT_W-1:0];
      end else if (apb_req_in.paddr == OFS_MASK) begin
        next_state.mask = apb_req_in.pwdata[STAT_W-1:0];
      end
    end

    // ---------------------------------------------------------------
    // status and interrupts
    // ---------------------------------------------------------------
    // a new event beats a same-cycle write-one-to-clear
    next_state.status = (state.status & ~clr_bits) | set_bits;
    for (int i = 0; i < NUM_CH; i++) begin
      next_state.ch_irq[i] = next_state.status[i] & next_state.mask[i];
    end
    next_state.irq = |(next_state.status & next_state.mask);
    // nmi ignores the mask on purpose
    next_state.nmi = next_state.status[WDG_STAT_BIT]
                     && state.wdg_act == TMW_WDG_NMI;

    // reset pulse of fixed width, restarted by each reset-mode expiry
    if (set_bits[WDG_STAT_BIT] && state.wdg_act == TMW_WDG_RESET) begin
      next_state.rst_cnt = 16'(WDG_RST_CYCLES);
    end else if (state.rst_cnt != 16'h0000) begin
      next_state.rst_cnt = state.rst_cnt - 16'h0001;
    end
    next_state.sys_rst = next_state.rst_cnt != 16'h0000;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      state          <= '0;
      state.load     <= {NUM_CH{RST_LOAD}};
      state.cnt      <= {NUM_CH{RST_LOAD}};
      state.wdg_load <= RST_WDG_LOAD;
      state.wdg_cnt  <= RST_WDG_LOAD;
      state.mask     <= RST_MASK;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign apb_rsp_out   = state.rsp;
  assign ch_irq_out    = state.ch_irq;
  assign irq_out       = state.irq;
  assign nmi_out       = state.nmi;
  assign sys_reset_out = state.sys_rst;

endmodule

// >>> verif/tmw_timers_sva.sv
// checker of the timer block: apb handshake, interrupt and system reset outputs.
// assumes it is bound to tmw_timers and sees only its ports.
`timescale 1ns/10ps
module tmw_timers_sva (
  input wire logic                  clock_in,
  input wire logic                  reset_n_in,
  input wire tmw_pkg::tmw_apb_req_s apb_req_in,
  input wire tmw_pkg::tmw_apb_rsp_s apb_rsp_out,
  input wire logic [3:0]            ch_irq_out,
  input wire logic                  irq_out,
  input wire logic                  nmi_out,
  input wire logic                  sys_reset_out
);
  import tmw_pkg::*;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  logic [15:0] run;
  // counts samples of the reset pulse, so its length needs no long repetition
  always_ff @(posedge clock_in) begin
    run <= (!reset_n_in || !sys_reset_out) ? 16'h0 : run + 16'h1;
  end
  property p_rdy_wait;
    apb_req_in.psel && apb_req_in.penable && !apb_rsp_out.pready |=> apb_rsp_out.pready;
  endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("pready late");
  property p_rdy_pulse;
    apb_rsp_out.pready |=> !apb_rsp_out.pready;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready too long");
  property p_rdy_req;
    apb_rsp_out.pready |-> apb_req_in.psel && apb_req_in.penable;
  endproperty
  a_rdy_req: assert property (p_rdy_req) else $error("pready without access");
  property p_wr_zero;
    apb_rsp_out.pready && apb_req_in.pwrite |-> apb_rsp_out.prdata == 32'h0;
  endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("read data on write");
  property p_irq_or;
    |ch_irq_out |-> irq_out;
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("channel irq not summed");
  property p_excl;
    !(nmi_out && sys_reset_out);
  endproperty
  a_excl: assert property (p_excl) else $error("nmi and reset together");
  property p_rst_hold;
    $rose(sys_reset_out) |=> sys_reset_out [*8];
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset pulse short");
  property p_rst_len;
    $fell(sys_reset_out) |-> run == 16'(WDG_RST_CYCLES);
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset pulse length");
  property p_nmi_stay;
    nmi_out && !(apb_rsp_out.pready && apb_req_in.pwrite && apb_req_in.paddr == OFS_STATUS
      && apb_req_in.pwdata[WDG_STAT_BIT]) |=> nmi_out;
  endproperty
  a_nmi_stay: assert property (p_nmi_stay) else $error("nmi dropped");
endmodule
bind tmw_timers tmw_timers_sva i_sva (.clock_in, .reset_n_in, .apb_req_in, .apb_rsp_out,
  .ch_irq_out, .irq_out, .nmi_out, .sys_reset_out);

// >>> verif/tmw_timers_test.sv
// self-checking bench of the timer block driven over apb.
// assumes tmw_pkg and tmw_timers; the checker is bound by its own file.
`timescale 1ns/10ps
module tmw_timers_test;
  import tmw_pkg::*;
  logic         clock_in;
  logic         reset_n_in;
  tmw_apb_req_s req;
  tmw_apb_rsp_s rsp;
  logic [3:0]   ch_irq;
  logic         irq;
  logic         nmi;
  logic         srst;
  int           n_mismatch;
  int           num_checks;
  logic [31:0]  q;
  logic         e;
  wire logic [5:0] evt = {srst, nmi, ch_irq};
  logic [7:0]   ra [10] = '{8'h00, 8'h10, 8'h1c, 8'h2c, 8'h30, 8'h34, 8'h3c, 8'h40, 8'h44, 8'h48};
  logic [32:0]  rx [10] = '{33'h0, 33'hffffffff, 33'hffffffff, 33'hffffffff, 33'h0,
                            33'hffffffff, 33'hffffffff, 33'h0, 33'h0, 33'h100000000};
  tmw_timers i_dut (.clock_in, .reset_n_in, .apb_req_in(req), .apb_rsp_out(rsp),
    .ch_irq_out(ch_irq), .irq_out(irq), .nmi_out(nmi), .sys_reset_out(srst));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task fail;
    n_mismatch++;
    summarize;
  endtask
  // answer is read right at the rising edge, before the flops' non-blocking update
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_in) req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock_in) req.penable <= 1'b1;
    do begin @(posedge clock_in); n++; end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1) fail;
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
    // let the outputs settle before any compare that follows
    @(negedge clock_in);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk({e, q}, {1'b0, x});
  endtask
  task wt(input int s);
    int n;
    n = 0;
    while (evt[s] !== 1'b1 && n < 600) begin @(negedge clock_in); n++; end
    if (evt[s] !== 1'b1) fail;
  endtask
  initial begin
    int n;
    reset_n_in = 1'b0;
    req = '0;
    repeat (2) @(posedge clock_in);
    reset_n_in <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk({e, q}, rx[i]);
    end
    apb(1'b1, 8'h20, 32'h0);
    rd(8'h20, 32'hffffffff);
    apb(1'b1, OFS_LOAD_BASE, 32'ha5a5a5a5);
    rd(8'h20, 32'ha5a5a5a5);
    apb(1'b1, OFS_MASK, 32'h1f);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OFS_LOAD_BASE + 8'(i * 4), 32'h3);
      apb(1'b1, OFS_CTRL, 32'h11 << i);
      wt(i);
      chk(irq, 1);
      rd(OFS_CTRL, 32'h10 << i);
      apb(1'b1, OFS_STATUS, 32'h1 << i);
      chk(ch_irq, 0);
    end
    // masked timer keeps running and re-firing, interrupt stays low
    apb(1'b1, OFS_MASK, 32'h0);
    apb(1'b1, OFS_LOAD_BASE, 32'h2);
    apb(1'b1, OFS_CTRL, 32'h1);
    repeat (20) @(negedge clock_in);
    chk(irq, 0);
    rd(OFS_STATUS, 32'h1);
    rd(OFS_CTRL, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_STATUS, 32'h1f);
    apb(1'b1, OFS_WDG_LOAD, 32'd40);
    apb(1'b1, OFS_WDG_CTRL, 32'h1);
    repeat (6) begin
      repeat (20) @(negedge clock_in);
      apb(1'b1, OFS_WDG_SVC, 32'h0);
    end
    chk(nmi, 0);
    apb(1'b1, OFS_WDG_CTRL, 32'h0);
    rd(OFS_WDG_CTRL, 32'h1);
    wt(4);
    rd(OFS_STATUS, 32'h10);
    chk({srst, irq}, 0);
    apb(1'b1, OFS_STATUS, 32'h10);
    chk(nmi, 0);
    @(posedge clock_in) reset_n_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    reset_n_in <= 1'b1;
    apb(1'b1, OFS_WDG_LOAD, 32'd200);
    apb(1'b1, OFS_WDG_CTRL, 32'h3);
    wt(5);
    n = 0;
    while (srst === 1'b1 && n < 300) begin @(negedge clock_in); n++; end
    chk(33'(n), 33'(WDG_RST_CYCLES));
    chk(nmi, 0);
    summarize;
  end
endmodule
